// file: core/cgr_pkg.sv
// Constants and types shared by the general register file
package cgr_pkg;
    localparam int unsigned WORD_W      = 32;
    localparam int unsigned IDX_W       = 4;
    localparam int unsigned NUM_REGS    = 16;
    localparam int unsigned SEG_W       = 4;
    localparam int unsigned SEG_LSB     = 28;
    localparam int unsigned GROUP_BIT   = 3;
    localparam logic [3:0]  IMPLICIT_D  = 4'hf;
    localparam logic [3:0]  STACK_A     = 4'ha;
    localparam logic [3:0]  RETURN_A    = 4'hb;
    localparam logic [3:0]  IMPLICIT_A  = 4'hf;
    localparam logic [15:0] GLOBAL_MASK = 16'h0303;
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic [31:0] PC_RESET    = 32'h0000_0000;
    localparam logic [31:0] LINK_RESET  = 32'h0000_0000;
    localparam logic [31:0] STAT_RESET  = 32'h0000_0000;
    // Writable bits of the status word; the rest are reserved_field
    localparam logic [31:0] STAT_WMASK  = 32'h0000_ffff;
    localparam logic [31:0] LINK_WMASK  = 32'hffff_ffff;
    typedef logic [WORD_W-1:0] cgr_word_t;
    typedef logic [IDX_W-1:0]  cgr_idx_t;
endpackage

// file: core/cgr_bank_if.sv
// Interface between the register file top and one register bank
`timescale 1ns/100ps
interface cgr_bank_if;
    logic                wr_en;
    cgr_pkg::cgr_idx_t   wr_idx;
    cgr_pkg::cgr_word_t  wr_data;
    logic                grp_ld;
    logic                grp_upper;
    cgr_pkg::cgr_word_t  grp_data [8];
    cgr_pkg::cgr_word_t  regs [16];
    modport ctrl (output wr_en, wr_idx, wr_data, grp_ld, grp_upper,
                  grp_data, input regs);
    modport bank (input wr_en, wr_idx, wr_data, grp_ld, grp_upper,
                  grp_data, output regs);
endinterface

// file: core/cgr_bank.sv
// One bank of sixteen 32-bit general registers with group restore
`timescale 1ns/100ps
module cgr_bank #(
    parameter logic [15:0] SKIP_MASK = 16'h0000
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    cgr_bank_if.bank  bus
);
    for (genvar g = 0; g < 16; g++) begin : g_reg
        localparam logic [3:0] IDX = 4'(g);
        localparam bit UPPER = (g >= 8);
        wire grp_hit = bus.grp_ld && (bus.grp_upper == UPPER)
                       && !SKIP_MASK[g];
        wire wr_hit  = bus.wr_en && (bus.wr_idx == IDX);
        always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
                bus.regs[g] <= cgr_pkg::REG_RESET;
            end else if (grp_hit) begin
                bus.regs[g] <= bus.grp_data[g % 8];
            end else if (wr_hit) begin
                bus.regs[g] <= bus.wr_data;
            end
        end
    end
endmodule

// file: core/cgr_regfile.sv
// Architectural general register file, status registers and segment map
`timescale 1ns/100ps
module cgr_regfile (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire logic               d_wr_en_i,
    input  wire cgr_pkg::cgr_idx_t  d_wr_idx_i,
    input  wire cgr_pkg::cgr_word_t d_wr_data_i,
    input  wire logic               a_wr_en_i,
    input  wire cgr_pkg::cgr_idx_t  a_wr_idx_i,
    input  wire cgr_pkg::cgr_word_t a_wr_data_i,
    input  wire logic               d_rd_implicit_i,
    input  wire cgr_pkg::cgr_idx_t  d_rd_idx_i,
    input  wire logic               a_rd_implicit_i,
    input  wire cgr_pkg::cgr_idx_t  a_rd_idx_i,
    input  wire logic               ctx_ld_i,
    input  wire logic               ctx_upper_i,
    input  wire cgr_pkg::cgr_word_t ctx_d_i [8],
    input  wire cgr_pkg::cgr_word_t ctx_a_i [8],
    input  wire logic               pc_ld_i,
    input  wire cgr_pkg::cgr_word_t pc_i,
    input  wire logic               link_wr_i,
    input  wire cgr_pkg::cgr_word_t link_i,
    input  wire logic               status_wr_i,
    input  wire cgr_pkg::cgr_word_t status_i,
    input  wire logic               status_hw_en_i,
    input  wire cgr_pkg::cgr_word_t status_hw_i,
    input  wire cgr_pkg::cgr_word_t byte_addr_i,
    output logic [31:0]             d_rd_data_o,
    output logic [31:0]             a_rd_data_o,
    output logic [31:0]             stack_pointer_o,
    output logic [31:0]             return_address_reg_o,
    output logic [31:0]             pc_o,
    output logic [31:0]             previous_context_link_o,
    output logic [31:0]             program_status_word_o,
    output logic [3:0]              segment_o,
    output logic [27:0]             seg_offset_o,
    output logic [7:0]              mem_byte0_o,
    output logic [7:0]              mem_byte3_o
);
    // All checks below sample on the core clock and rest during reset
    default clocking cb_main @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    cgr_bank_if d_if ();
    cgr_bank_if a_if ();

    // Data bank keeps every register in its group
    cgr_bank #(.SKIP_MASK(16'h0000)) u_dbank (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .bus       (d_if.bank)
    );
    // Global address registers never take part in group restore
    cgr_bank #(.SKIP_MASK(cgr_pkg::GLOBAL_MASK)) u_abank (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .bus       (a_if.bank)
    );

    assign d_if.wr_en     = d_wr_en_i;
    assign d_if.wr_idx    = d_wr_idx_i;
    assign d_if.wr_data   = d_wr_data_i;
    assign d_if.grp_ld    = ctx_ld_i;
    assign d_if.grp_upper = ctx_upper_i;
    assign d_if.grp_data  = ctx_d_i;
    assign a_if.wr_en     = a_wr_en_i;
    assign a_if.wr_idx    = a_wr_idx_i;
    assign a_if.wr_data   = a_wr_data_i;
    assign a_if.grp_ld    = ctx_ld_i;
    assign a_if.grp_upper = ctx_upper_i;
    assign a_if.grp_data  = ctx_a_i;

    // Implicit operand substitution
    wire cgr_pkg::cgr_idx_t d_sel = d_rd_implicit_i ? cgr_pkg::IMPLICIT_D
                                                    : d_rd_idx_i;
    wire cgr_pkg::cgr_idx_t a_sel = a_rd_implicit_i ? cgr_pkg::IMPLICIT_A
                                                    : a_rd_idx_i;

    // Group restore result for a register, if it is being reloaded
    wire d_grp_hit = ctx_ld_i && (d_sel[cgr_pkg::GROUP_BIT] == ctx_upper_i);
    wire a_grp_hit = ctx_ld_i && (a_sel[cgr_pkg::GROUP_BIT] == ctx_upper_i)
                     && !cgr_pkg::GLOBAL_MASK[a_sel];
    wire d_wr_hit  = d_wr_en_i && (d_wr_idx_i == d_sel);
    wire a_wr_hit  = a_wr_en_i && (a_wr_idx_i == a_sel);

    // Bypass: read returns the value the register takes at this edge
    wire cgr_pkg::cgr_word_t next_d_rd =
        d_grp_hit ? ctx_d_i[d_sel[2:0]] :
        d_wr_hit  ? d_wr_data_i : d_if.regs[d_sel];
    wire cgr_pkg::cgr_word_t next_a_rd =
        a_grp_hit ? ctx_a_i[a_sel[2:0]] :
        a_wr_hit  ? a_wr_data_i : a_if.regs[a_sel];

    wire upper_ld = ctx_ld_i && ctx_upper_i;
    wire cgr_pkg::cgr_word_t next_stack =
        upper_ld ? ctx_a_i[cgr_pkg::STACK_A[2:0]] :
        (a_wr_en_i && a_wr_idx_i == cgr_pkg::STACK_A) ? a_wr_data_i
        : a_if.regs[cgr_pkg::STACK_A];
    wire cgr_pkg::cgr_word_t next_ret =
        upper_ld ? ctx_a_i[cgr_pkg::RETURN_A[2:0]] :
        (a_wr_en_i && a_wr_idx_i == cgr_pkg::RETURN_A) ? a_wr_data_i
        : a_if.regs[cgr_pkg::RETURN_A];

    // Status word: hardware update wins and is stored unmasked; software writes hold reserved bits at zero
    wire cgr_pkg::cgr_word_t next_status =
        status_hw_en_i ? status_hw_i :
        status_wr_i ? (status_i & cgr_pkg::STAT_WMASK)
                    : program_status_word_o;
    wire cgr_pkg::cgr_word_t next_link =
        link_wr_i ? (link_i & cgr_pkg::LINK_WMASK)
                  : previous_context_link_o;

    // Little-endian: byte 0 is the least significant byte of the word
    wire [7:0] next_b0 = next_d_rd[7:0];
    wire [7:0] next_b3 = next_d_rd[31:24];

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            d_rd_data_o             <= cgr_pkg::REG_RESET;
            a_rd_data_o             <= cgr_pkg::REG_RESET;
            stack_pointer_o         <= cgr_pkg::REG_RESET;
            return_address_reg_o    <= cgr_pkg::REG_RESET;
            pc_o                    <= cgr_pkg::PC_RESET;
            previous_context_link_o <= cgr_pkg::LINK_RESET;
            program_status_word_o   <= cgr_pkg::STAT_RESET;
            segment_o               <= 4'h0;
            seg_offset_o            <= 28'h000_0000;
            mem_byte0_o             <= 8'h00;
            mem_byte3_o             <= 8'h00;
        end else begin
            d_rd_data_o             <= next_d_rd;
            a_rd_data_o             <= next_a_rd;
            stack_pointer_o         <= next_stack;
            return_address_reg_o    <= next_ret;
            if (pc_ld_i) begin
                pc_o <= pc_i;
            end
            previous_context_link_o <= next_link;
            program_status_word_o   <= next_status;
            segment_o    <= byte_addr_i[cgr_pkg::SEG_LSB +: cgr_pkg::SEG_W];
            seg_offset_o <= byte_addr_i[cgr_pkg::SEG_LSB-1:0];
            mem_byte0_o  <= next_b0;
            mem_byte3_o  <= next_b3;
        end
    end

    // Special roles of A10, A11, D15 and A15
    a_stack_track: assert property (
        (a_wr_en_i && a_wr_idx_i == cgr_pkg::STACK_A && !ctx_ld_i)
        |=> stack_pointer_o == $past(a_wr_data_i))
        else $error("stack pointer did not follow write");
    a_ret_track: assert property (
        (a_wr_en_i && a_wr_idx_i == cgr_pkg::RETURN_A && !ctx_ld_i)
        |=> return_address_reg_o == $past(a_wr_data_i))
        else $error("return address did not follow write");
    a_d_implicit: assert property (
        (d_rd_implicit_i && !d_wr_en_i && !ctx_ld_i)
        |=> d_rd_data_o == d_if.regs[cgr_pkg::IMPLICIT_D])
        else $error("implicit data read wrong");
    a_a_implicit: assert property (
        (a_rd_implicit_i && !a_wr_en_i && !ctx_ld_i)
        |=> a_rd_data_o == a_if.regs[cgr_pkg::IMPLICIT_A])
        else $error("implicit address read wrong");

    // Same-cycle reads see the value written at this edge
    a_bypass_d: assert property (
        (d_wr_en_i && !d_rd_implicit_i && d_wr_idx_i == d_rd_idx_i
         && !ctx_ld_i) |=> d_rd_data_o == $past(d_wr_data_i))
        else $error("same-cycle read missed bypass");
    a_bypass_a: assert property (
        (a_wr_en_i && !a_rd_implicit_i && a_wr_idx_i == a_rd_idx_i
         && !ctx_ld_i) |=> a_rd_data_o == $past(a_wr_data_i))
        else $error("same-cycle address read missed bypass");

    // Group restore: globals untouched, the rest take the group words
    a_global_keep: assert property (
        (ctx_ld_i && !a_wr_en_i) |=> a_if.regs[0] == $past(a_if.regs[0])
        && a_if.regs[9] == $past(a_if.regs[9]))
        else $error("global register restored");
    a_global_more: assert property (
        (ctx_ld_i && !a_wr_en_i) |=> a_if.regs[1] == $past(a_if.regs[1])
        && a_if.regs[8] == $past(a_if.regs[8]))
        else $error("global register restored");
    a_group_load: assert property (
        (ctx_ld_i && ctx_upper_i) |=> d_if.regs[12] == $past(ctx_d_i[4]))
        else $error("upper group restore wrong");
    a_lower_load: assert property (
        (ctx_ld_i && !ctx_upper_i) |=> a_if.regs[2] == $past(ctx_a_i[2]))
        else $error("lower group restore wrong");

    // Status word, context link and program counter
    a_status_rsvd: assert property (
        (status_wr_i && !status_hw_en_i)
        |=> (program_status_word_o & ~cgr_pkg::STAT_WMASK) == 32'h0000_0000)
        else $error("reserved status bits written");
    a_status_hw: assert property (
        status_hw_en_i |=> program_status_word_o == $past(status_hw_i))
        else $error("hardware status update lost");
    a_pc_load: assert property (
        pc_ld_i |=> pc_o == $past(pc_i))
        else $error("program counter load lost");
    a_link_wr: assert property (
        link_wr_i |=> previous_context_link_o
                      == ($past(link_i) & cgr_pkg::LINK_WMASK))
        else $error("context link write lost");

    // Address decode and byte order
    a_segment: assert property (
        1'b1 |=> segment_o == $past(byte_addr_i[31:28]))
        else $error("segment decode wrong");
    a_offset: assert property (
        1'b1 |=> seg_offset_o == $past(byte_addr_i[27:0]))
        else $error("segment offset wrong");
    a_byte_order: assert property (
        mem_byte0_o == d_rd_data_o[7:0]
        && mem_byte3_o == d_rd_data_o[31:24])
        else $error("byte lanes out of order");

    c_bypass: cover property (d_wr_en_i && d_wr_idx_i == d_rd_idx_i);
    c_lower_ld: cover property (ctx_ld_i && !ctx_upper_i);
    c_upper_ld: cover property (ctx_ld_i && ctx_upper_i);
    c_status_both: cover property (status_hw_en_i && status_wr_i);
    c_global_wr: cover property (ctx_ld_i && a_wr_en_i
        && cgr_pkg::GLOBAL_MASK[a_wr_idx_i]);
endmodule

// file: verification/cgr_pipe_model.sv
// Execute pipeline model that drives register writes and reads
`timescale 1ns/100ps
module cgr_pipe_model (
    output logic        d_we_o,
    output logic        a_we_o,
    output logic [3:0]  wi_o,
    output logic [31:0] d_wd_o,
    output logic [31:0] a_wd_o,
    output logic        imp_o,
    output logic [3:0]  ri_o
);
    initial begin
        {d_we_o, a_we_o, wi_o, imp_o, ri_o} = '0;
        d_wd_o = '0;
        a_wd_o = '0;
    end
    // Called at a falling edge; values stand until the next call
    task automatic op(input logic dw, aw, imp, input logic [3:0] i,
                      input logic [31:0] v);
        d_we_o <= dw;
        a_we_o <= aw;
        wi_o   <= i;
        d_wd_o <= v;
        a_wd_o <= ~v;
        imp_o  <= imp;
        ri_o   <= i;
    endtask
endmodule

// file: verification/test_core_gpr_file_and_segmap.sv
// Self-checking bench for the general register file
`timescale 1ns/100ps
module test_core_gpr_file_and_segmap;
    typedef struct packed {
        logic [3:0]  idx;
        logic [31:0] val;
    } cgr_row_t;
    localparam cgr_row_t ROWS [7] = '{
        '{4'h0, 32'h0000_0000}, '{4'h3, 32'h1fff_ff01},
        '{4'h7, 32'h8765_4321}, '{4'h8, 32'hf000_00ff},
        '{4'hf, 32'hc3c3_0f0f}, '{4'ha, 32'h5a00_00c3},
        '{4'hb, 32'h2400_0042}};
    localparam logic [31:0] HVAL = 32'h0000_00a5;
    logic               sys_clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic [5:0]         ctl = '0;
    logic [31:0]        sval = '0;
    logic               d_we, a_we, imp;
    logic [3:0]         wi, ri, seg;
    logic [31:0]        d_wd, a_wd, d_rd, a_rd, stk, ret, pc, link, stat;
    logic [27:0]        ofs;
    logic [7:0]         b0, b3;
    cgr_pkg::cgr_word_t ctx_d [8];
    cgr_pkg::cgr_word_t ctx_a [8];
    logic [31:0]        exp_d [16];
    logic [31:0]        exp_a [16];
    int                 failures = 0;
    int                 samples_checked = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    cgr_pipe_model i_pipe (.d_we_o(d_we), .a_we_o(a_we), .wi_o(wi),
        .d_wd_o(d_wd), .a_wd_o(a_wd), .imp_o(imp), .ri_o(ri));
    cgr_regfile i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .d_wr_en_i(d_we), .d_wr_idx_i(wi), .d_wr_data_i(d_wd),
        .a_wr_en_i(a_we), .a_wr_idx_i(wi), .a_wr_data_i(a_wd),
        .d_rd_implicit_i(imp), .d_rd_idx_i(ri),
        .a_rd_implicit_i(imp), .a_rd_idx_i(ri),
        .ctx_ld_i(ctl[5]), .ctx_upper_i(ctl[4]), .ctx_d_i(ctx_d),
        .ctx_a_i(ctx_a), .pc_ld_i(ctl[3]), .pc_i(sval),
        .link_wr_i(ctl[2]), .link_i(sval), .status_wr_i(ctl[1]),
        .status_i(sval), .status_hw_en_i(ctl[0]), .status_hw_i(HVAL),
        .byte_addr_i(d_wd), .d_rd_data_o(d_rd), .a_rd_data_o(a_rd),
        .stack_pointer_o(stk), .return_address_reg_o(ret), .pc_o(pc),
        .previous_context_link_o(link), .program_status_word_o(stat),
        .segment_o(seg), .seg_offset_o(ofs), .mem_byte0_o(b0),
        .mem_byte3_o(b3));
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            failures++;
        end
    endtask
    // One cycle of stimulus; results are looked at just after the edge
    task automatic step(input logic [5:0] c, input logic dw, aw, im,
                        input logic [3:0] i, input logic [31:0] v, s);
        @(negedge sys_clk_i);
        i_pipe.op(dw, aw, im, i, v);
        ctl <= c;
        sval <= s;
        if (dw) exp_d[i] = v;
        if (aw) exp_a[i] = ~v;
        for (int k = 0; k < 8; k++) begin
            if (c[5]) exp_d[{c[4], 3'(k)}] = ctx_d[k];
            if (c[5] && k > 1) exp_a[{c[4], 3'(k)}] = ctx_a[k];
        end
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic dump();
        for (int k = 0; k < 16; k++) begin
            step(6'h00, 1'b0, 1'b0, 1'b0, 4'(k), 32'h0, 32'h0);
            chk(d_rd, exp_d[k]);
            chk(a_rd, exp_a[k]);
        end
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        failures++;
        final_report();
    end
    initial begin
        for (int k = 0; k < 16; k++) begin
            exp_d[k] = '0;
            exp_a[k] = '0;
            if (k < 8) ctx_d[k] = 32'hd000_0000 | 32'(k);
            if (k < 8) ctx_a[k] = 32'ha000_0000 | 32'(k);
        end
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk(pc, cgr_pkg::PC_RESET);
        chk(stat, cgr_pkg::STAT_RESET);
        chk(link, cgr_pkg::LINK_RESET);
        chk(d_rd, cgr_pkg::REG_RESET);
        chk(stk, cgr_pkg::REG_RESET);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        foreach (ROWS[r]) begin
            step(6'h00, 1'b1, 1'b1, 1'b0, ROWS[r].idx, ROWS[r].val, 32'h0);
            chk(d_rd, ROWS[r].val);
            chk(a_rd, ~ROWS[r].val);
            chk({28'h0, seg}, {28'h0, ROWS[r].val[31:28]});
            chk({4'h0, ofs}, {4'h0, ROWS[r].val[27:0]});
            chk({24'h0, b0}, {24'h0, ROWS[r].val[7:0]});
            chk({24'h0, b3}, {24'h0, ROWS[r].val[31:24]});
        end
        chk(stk, exp_a[10]);
        chk(ret, exp_a[11]);
        step(6'h00, 1'b0, 1'b0, 1'b1, 4'h0, 32'h0, 32'h0);
        chk(d_rd, exp_d[15]);
        chk(a_rd, exp_a[15]);
        // Upper restore in the same cycle as writes to D9 and global A9
        step(6'h30, 1'b1, 1'b1, 1'b0, 4'h9, 32'h1234_5678, 32'h0);
        chk(stk, 32'ha000_0002);
        dump();
        step(6'h20, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0, 32'h0);
        dump();
        step(6'h02, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0, 32'hffff_ffff);
        chk(stat, 32'h0000_ffff);
        step(6'h02, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0, 32'h0000_1234);
        chk(stat, 32'h0000_1234);
        step(6'h03, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0, 32'hffff_ffff);
        chk(stat, HVAL);
        step(6'h0c, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0, 32'h8000_0104);
        chk(pc, 32'h8000_0104);
        chk(link, 32'h8000_0104);
        final_report();
    end
endmodule
